// ---- capture_compare_unit.sv ----
// Capture/compare array: two reloadable timers, sixteen channels.
// Assumes an APB master on pclk; pins and external counts are asynchronous.
// Behaviour
// - Sixteen channels; staggered mode resolution eight cycles
// - Two 16-bit timers with reload registers
// - Timer clock: prescaler or neighbour timer overflow
// - External count inputs advance the timers
// - Each channel picks timer and capture/compare
// - One pin per channel: input or output
// - Capture copies assigned timer on pin event
// - Capture raises the channel's interrupt request
// - Capture edge: rising, falling or both
// - Compare channels match against timer after each count
// - Mode 0: interrupt on every match
// - Mode 1: pin toggles on every match
// - Mode 2: interrupt once per period
// - Mode 3: set on match, clear on overflow
// - Double register: two channels toggle one pin
// - Single event: one compare action only
module capture_compare_unit (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [cc_pkg::AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic neighbour_timer_six_ovf,
  input wire logic [1:0] ext_count,
  input wire logic [cc_pkg::NCH-1:0] cc_pin_in,
  output logic [cc_pkg::NCH-1:0] cc_pin_out,
  output logic [cc_pkg::NCH-1:0] cc_pin_oe_n,
  output logic irq
);
  import cc_pkg::*;

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  logic setup;
  logic wr;
  logic [31:0] rd_d;
  logic err_d;
  logic err_q;
  tmr_ctl_s tctl_q [2];
  logic [TW-1:0] tcnt_q [2];
  logic [TW-1:0] trel_q [2];
  logic stag_q;
  logic [NIRQ-1:0] stat_q;
  logic [NIRQ-1:0] mask_q;
  chan_cfg_s cfg_q [NCH];
  logic [TW-1:0] val_q [NCH];
  logic [NCH-1:0] pin_q;
  logic [NCH-1:0] pin_s;
  logic [NIRQ-1:0] evt;
  assign setup = psel & ~penable;
  // Zero wait states: read data is latched in the setup cycle
  assign pready = 1'b1;
  assign pslverr = psel & penable & err_q;
  assign wr = psel & penable & pwrite & ~err_q;
  always_comb begin
    rd_d = 32'h0;
    err_d = 1'b0;
    if (paddr[11:6] == CFG_PAGE) begin
      rd_d[7:0] = cfg_q[paddr[5:2]];
    end else if (paddr[11:6] == VAL_PAGE) begin
      rd_d[TW-1:0] = val_q[paddr[5:2]];
    end else begin
      unique case (paddr)
        TCTL0: rd_d[3:0] = tctl_q[0];
        TCNT0: rd_d[TW-1:0] = tcnt_q[0];
        TREL0: rd_d[TW-1:0] = trel_q[0];
        TCTL1: rd_d[3:0] = tctl_q[1];
        TCNT1: rd_d[TW-1:0] = tcnt_q[1];
        TREL1: rd_d[TW-1:0] = trel_q[1];
        GCTL: rd_d[GCTL_STAG] = stag_q;
        ISTAT: rd_d[NIRQ-1:0] = stat_q;
        IMASK: rd_d[NIRQ-1:0] = mask_q;
        PINST: rd_d = {pin_s, pin_q};
        default: err_d = 1'b1;
      endcase
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
      err_q <= 1'b0;
    end else if (setup) begin
      prdata <= rd_d;
      err_q <= err_d;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stag_q <= 1'b0;
      mask_q <= '0;
    end else if (wr && paddr == GCTL) begin
      stag_q <= pwdata[GCTL_STAG];
    end else if (wr && paddr == IMASK) begin
      mask_q <= pwdata[NIRQ-1:0];
    end
  end
  // ----------------------------------------
  // Interrupt status
  // ----------------------------------------
  // Set wins over a write-one clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_q <= '0;
    end else if (wr && paddr == ISTAT) begin
      stat_q <= (stat_q & ~pwdata[NIRQ-1:0]) | evt;
    end else begin
      stat_q <= stat_q | evt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |((stat_q | evt) & mask_q);
    end
  end

  // ----------------------------------------
  // Clock enables
  // ----------------------------------------
  logic [3:0] pre_q;
  logic [2:0] stg_q;
  logic stg_tick;
  logic [1:0] ext_s1;
  logic [1:0] ext_s2;
  logic [1:0] ext_s3;
  logic [1:0] ext_rise;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_q <= 4'h0;
      stg_q <= 3'h0;
    end else begin
      pre_q <= pre_q + 4'h1;
      stg_q <= stg_q + 3'h1;
    end
  end
  // Staggered: prescaler-clocked timers advance at most once in eight cycles
  assign stg_tick = ~stag_q | (stg_q == 3'(STAGGER_CYC - 1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_s1 <= 2'h0;
      ext_s2 <= 2'h0;
      ext_s3 <= 2'h0;
    end else begin
      ext_s1 <= ext_count;
      ext_s2 <= ext_s1;
      ext_s3 <= ext_s2;
    end
  end
  assign ext_rise = ext_s2 & ~ext_s3;

  // ----------------------------------------
  // Timers
  // ----------------------------------------
  logic [1:0] tick;
  logic [1:0] tovf;
  logic [1:0] tupd_q;
  logic [1:0] tovf_q;

  for (genvar t = 0; t < 2; t++) begin : g_tmr
    logic [3:0] msk;
    logic [AW-1:0] a_ctl;
    logic [AW-1:0] a_cnt;
    logic [AW-1:0] a_rel;
    assign a_ctl = (t == 0) ? TCTL0 : TCTL1;
    assign a_cnt = (t == 0) ? TCNT0 : TCNT1;
    assign a_rel = (t == 0) ? TREL0 : TREL1;
    assign msk = 4'((5'h1 << tctl_q[t].clk_sel) - 5'h1);
    always_comb begin
      tick[t] = 1'b0;
      if (tctl_q[t].run) begin
        if (tctl_q[t].clk_sel <= CS_MAXPRE) begin
          tick[t] = ((pre_q & msk) == msk) & stg_tick;
        end else if (tctl_q[t].clk_sel == CS_NEIGH) begin
          tick[t] = neighbour_timer_six_ovf;
        end else if (tctl_q[t].clk_sel == CS_EXT) begin
          tick[t] = ext_rise[t];
        end
      end
    end
    assign tovf[t] = tick[t] & (tcnt_q[t] == TMAX);
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        tctl_q[t] <= TCTL_RST;
        trel_q[t] <= TRST;
      end else if (wr && paddr == a_ctl) begin
        tctl_q[t] <= pwdata[3:0];
      end else if (wr && paddr == a_rel) begin
        trel_q[t] <= pwdata[TW-1:0];
      end
    end
    // Software count write wins over a tick
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        tcnt_q[t] <= TRST;
      end else if (wr && paddr == a_cnt) begin
        tcnt_q[t] <= pwdata[TW-1:0];
      end else if (tovf[t]) begin
        tcnt_q[t] <= trel_q[t];
      end else if (tick[t]) begin
        tcnt_q[t] <= tcnt_q[t] + 16'h1;
      end
    end
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        tupd_q[t] <= 1'b0;
        tovf_q[t] <= 1'b0;
      end else begin
        tupd_q[t] <= tick[t];
        tovf_q[t] <= tovf[t];
      end
    end
  end
  assign evt[TOVF_BIT+1:TOVF_BIT] = tovf;

  // ----------------------------------------
  // Channels
  // ----------------------------------------
  logic [NCH-1:0] fire;
  logic [NCH-1:0] cap;
  logic [NCH-1:0] ovf_c;
  logic [NCH-1:0] armed_q;
  logic [NCH-1:0] spent_q;
  logic [TW-1:0] tv [NCH];
  assign cc_pin_out = pin_q;

  for (genvar i = 0; i < NCH; i++) begin : g_ch
    logic s1;
    logic s2;
    logic s3;
    logic upd;
    logic is_cmp;
    logic once;
    logic dtog;
    logic cwr;
    assign cwr = wr && paddr[11:6] == CFG_PAGE && paddr[5:2] == 4'(i);
    assign tv[i] = tcnt_q[cfg_q[i].tsel];
    assign upd = tupd_q[cfg_q[i].tsel];
    assign ovf_c[i] = tovf_q[cfg_q[i].tsel];
    assign is_cmp = cfg_q[i].mode[2];
    assign once = cfg_q[i].mode == CM_CMP2 || cfg_q[i].mode == CM_CMP3;
    // Compare against the freshly counted value
    assign fire[i] = is_cmp & upd & (tv[i] == val_q[i]) & ~spent_q[i]
                     & (~once | armed_q[i] | ovf_c[i]);
    assign evt[i] = fire[i] | cap[i];
    // Pin sync feeds the readback only after stage two
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        s1 <= 1'b0;
        s2 <= 1'b0;
        s3 <= 1'b0;
      end else begin
        s1 <= cc_pin_in[i];
        s2 <= s1;
        s3 <= s2;
      end
    end
    assign pin_s[i] = s2;
    assign cap[i] = cfg_q[i].mode == CM_CAPTURE
                    & ((cfg_q[i].edge_sel[0] & s2 & ~s3)
                    | (cfg_q[i].edge_sel[1] & ~s2 & s3));
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        cfg_q[i] <= CFG_RST;
      end else if (cwr) begin
        cfg_q[i] <= pwdata[7:0];
      end
    end
    // Hardware capture wins over a software write
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        val_q[i] <= TRST;
      end else if (cap[i]) begin
        val_q[i] <= tv[i];
      end else if (wr && paddr[11:6] == VAL_PAGE && paddr[5:2] == 4'(i)) begin
        val_q[i] <= pwdata[TW-1:0];
      end
    end
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        armed_q[i] <= 1'b1;
      end else if (fire[i] && once) begin
        armed_q[i] <= 1'b0;
      end else if (ovf_c[i]) begin
        armed_q[i] <= 1'b1;
      end
    end
    // Rewriting the configuration re-arms a single event
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        spent_q[i] <= 1'b0;
      end else if (fire[i] && cfg_q[i].single) begin
        spent_q[i] <= 1'b1;
      end else if (cwr) begin
        spent_q[i] <= 1'b0;
      end
    end
    if (i < NCH / 2) begin : g_dbl
      assign dtog = cfg_q[i].dbl & fire[i+NCH/2];
    end else begin : g_nodbl
      assign dtog = 1'b0;
    end
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        pin_q[i] <= 1'b0;
      end else if (fire[i] && cfg_q[i].mode == CM_CMP3 && !cfg_q[i].dbl) begin
        pin_q[i] <= 1'b1;
      end else if (fire[i] && (cfg_q[i].mode == CM_CMP1 || cfg_q[i].dbl)) begin
        pin_q[i] <= ~pin_q[i] ^ dtog;
      end else if (dtog) begin
        pin_q[i] <= ~pin_q[i];
      end else if (ovf_c[i] && cfg_q[i].mode == CM_CMP3 && !cfg_q[i].dbl) begin
        pin_q[i] <= 1'b0;
      end
    end
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        cc_pin_oe_n[i] <= 1'b1;
      end else begin
        cc_pin_oe_n[i] <= !(cfg_q[i].mode == CM_CMP1
                          || cfg_q[i].mode == CM_CMP3 || cfg_q[i].dbl);
      end
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  property p_capture_value;
    @(posedge pclk) disable iff (!presetn)
    cap[0] |=> val_q[0] == $past(tv[0]);
  endproperty
  a_capture_value: assert property (p_capture_value) else $error("capture value wrong");
  property p_capture_irq;
    @(posedge pclk) disable iff (!presetn)
    cap[0] |=> stat_q[0] && (irq || !$past(mask_q[0]));
  endproperty
  a_capture_irq: assert property (p_capture_irq) else $error("capture irq missing");
  property p_edge_fall_only;
    @(posedge pclk) disable iff (!presetn)
    cfg_q[7].edge_sel == EDGE_FALL && cap[7] |-> !pin_s[7];
  endproperty
  a_edge_fall_only: assert property (p_edge_fall_only) else $error("capture on wrong edge");
  property p_toggle;
    @(posedge pclk) disable iff (!presetn)
    fire[1] && cfg_q[1].mode == CM_CMP1 && !g_ch[1].dtog |=> pin_q[1] != $past(pin_q[1]);
  endproperty
  a_toggle: assert property (p_toggle) else $error("mode 1 pin did not toggle");
  property p_mode0_pin;
    @(posedge pclk) disable iff (!presetn)
    cfg_q[3].mode == CM_CMP0 && !cfg_q[3].dbl && !g_ch[3].dtog |=> $stable(pin_q[3]);
  endproperty
  a_mode0_pin: assert property (p_mode0_pin) else $error("mode 0 moved the pin");
  property p_mode2_once;
    @(posedge pclk) disable iff (!presetn)
    fire[6] && cfg_q[6].mode == CM_CMP2 |=> !fire[6] || ovf_c[6];
  endproperty
  a_mode2_once: assert property (p_mode2_once) else $error("mode 2 fired twice");
  property p_mode3_set;
    @(posedge pclk) disable iff (!presetn)
    fire[2] && cfg_q[2].mode == CM_CMP3 && !cfg_q[2].dbl |=> pin_q[2];
  endproperty
  a_mode3_set: assert property (p_mode3_set) else $error("mode 3 pin not set");
  property p_single;
    @(posedge pclk) disable iff (!presetn)
    fire[4] && cfg_q[4].single && !g_ch[4].cwr |=> spent_q[4] && !fire[4];
  endproperty
  a_single: assert property (p_single) else $error("single event repeated");
  property p_reload;
    @(posedge pclk) disable iff (!presetn)
    tovf[0] && !(wr && paddr == TCNT0) |=> tcnt_q[0] == $past(trel_q[0]) && tovf_q[0];
  endproperty
  a_reload: assert property (p_reload) else $error("timer did not reload");
  property p_stagger;
    @(posedge pclk) disable iff (!presetn)
    stag_q && tick[1] && tctl_q[1].clk_sel <= CS_MAXPRE |-> stg_q == 3'h7;
  endproperty
  a_stagger: assert property (p_stagger) else $error("staggered tick misplaced");
endmodule

// ---- cc_pkg.sv ----
// Constants and types of the capture/compare array.
// Assumes an APB slave with a 12-bit byte address.
package cc_pkg;
  // ----------------------------------------
  // Sizes
  // ----------------------------------------
  localparam int NCH = 16;
  localparam int TW = 16;
  localparam int AW = 12;
  localparam int STAGGER_CYC = 8;
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [AW-1:0] TCTL0 = 12'h000;
  localparam logic [AW-1:0] TCNT0 = 12'h004;
  localparam logic [AW-1:0] TREL0 = 12'h008;
  localparam logic [AW-1:0] TCTL1 = 12'h00c;
  localparam logic [AW-1:0] TCNT1 = 12'h010;
  localparam logic [AW-1:0] TREL1 = 12'h014;
  localparam logic [AW-1:0] GCTL = 12'h018;
  localparam logic [AW-1:0] ISTAT = 12'h01c;
  localparam logic [AW-1:0] IMASK = 12'h020;
  localparam logic [AW-1:0] PINST = 12'h024;
  localparam logic [5:0] CFG_PAGE = 6'h01;
  localparam logic [5:0] VAL_PAGE = 6'h02;
  // ----------------------------------------
  // Fields and reset values
  // ----------------------------------------
  localparam int NIRQ = NCH + 2;
  localparam int TOVF_BIT = NCH;
  localparam int GCTL_STAG = 0;
  localparam logic [2:0] CS_NEIGH = 3'h5;
  localparam logic [2:0] CS_EXT = 3'h6;
  localparam logic [2:0] CS_MAXPRE = 3'h4;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [TW-1:0] TMAX = 16'hffff;
  localparam logic [TW-1:0] TRST = 16'h0000;
  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [2:0] {
    CM_OFF, CM_CAPTURE, CM_RSV2, CM_RSV3,
    CM_CMP0, CM_CMP1, CM_CMP2, CM_CMP3
  } cc_mode_e;
  typedef struct packed {
    logic [1:0] edge_sel;
    logic single;
    logic dbl;
    logic tsel;
    cc_mode_e mode;
  } chan_cfg_s;
  typedef struct packed {
    logic run;
    logic [2:0] clk_sel;
  } tmr_ctl_s;
  localparam chan_cfg_s CFG_RST = '{2'h0, 1'b0, 1'b0, 1'b0, CM_OFF};
  localparam tmr_ctl_s TCTL_RST = '{1'b0, 3'h0};
endpackage

// ---- pin_model.sv ----
// Pin side of the capture/compare array: sets input levels, counts output edges.
// Assumes the bench calls drive() and reads edge_cnt; one pclk domain.
module pin_model (
  input wire logic pclk,
  input wire logic [cc_pkg::NCH-1:0] pin_out,
  input wire logic [cc_pkg::NCH-1:0] pin_oe_n,
  output logic [cc_pkg::NCH-1:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  import cc_pkg::*;
  logic [NCH-1:0] ext_q = '0;
  logic [NCH-1:0] last_q = '0;
  int unsigned edge_cnt [NCH] = '{default: 0};
  // ----------------------------------------
  // Wire level
  // ----------------------------------------
  // Unit wins where it drives; elsewhere our own level
  assign pin_in = (pin_oe_n & ext_q) | (~pin_oe_n & pin_out);
  // Counted from the register, so a stuck enable still shows
  always @(posedge pclk) begin
    last_q <= pin_out;
    for (int i = 0; i < NCH; i++) begin
      if (pin_out[i] !== last_q[i]) edge_cnt[i] <= edge_cnt[i] + 1;
    end
  end
  task automatic drive(input int i, input logic v);
    @(posedge pclk);
    ext_q[i] <= v;
  endtask
endmodule

// ---- test_capture_compare_array.sv ----
// Self-checking bench for the capture/compare array over APB.
// Assumes cc_pkg, capture_compare_unit and pin_model are compiled first.
module test_capture_compare_array;
  timeunit 1ns;
  timeprecision 1ps;
  import cc_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, nb_ovf = 0;
  logic [AW-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, irq, rerr;
  logic [1:0] ext_count = '0;
  logic [NCH-1:0] pin_in, pin_out, pin_oe_n;
  int err_count = 0, check_count = 0;
  int unsigned e0 [NCH];
  localparam int CH [7] = '{1, 2, 4, 5, 13, 3, 6};
  localparam logic [31:0] CF [7] = '{32'h05, 32'h07, 32'h25, 32'h15, 32'h04, 32'h04, 32'h06};
  localparam logic [31:0] CV [7] = '{32'hfff0, 32'hfff0, 32'hfff0, 32'hffe8, 32'hfff8, 32'hfff4, 32'hfff0};
  always #5 pclk = ~pclk;
  capture_compare_unit dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .neighbour_timer_six_ovf(nb_ovf), .ext_count(ext_count), .cc_pin_in(pin_in), .cc_pin_out(pin_out),
    .cc_pin_oe_n(pin_oe_n), .irq(irq));
  pin_model pm (.pclk(pclk), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_in(pin_in));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // One idle edge after each transfer keeps drivers single per time step
  task automatic apb(input logic wr, input logic [AW-1:0] a, input logic [31:0] d);
    int n;
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      err_count++;
      test_done();
    end
    rd = prdata;
    rerr = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [AW-1:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rchk(input logic [AW-1:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rd, exp);
  endtask
  task automatic wait_irq(input logic v);
    int n;
    n = 0;
    while (irq !== v && n < 20) begin
      @(posedge pclk);
      n++;
    end
    check(32'(irq), 32'(v));
  endtask
  task automatic cnt_chk(input int i, input int exp);
    check(pm.edge_cnt[i] - e0[i], 32'(exp));
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    check(32'(pin_oe_n), 32'hffff);
    check(32'(pin_out), 32'h0);
    check(32'(irq), 32'h0);
    check(32'(pready), 32'h1);
    rchk(TCTL0, 32'h0);
    rchk(ISTAT, 32'h0);
    apb(1'b0, 12'h03c, 32'h0);
    check(32'(rerr), 32'h1);
    check(rd, 32'h0);
    $display("test reset done");
    // Period of 32 ticks; all compare events clear of the first 5 ticks
    wr(TREL0, 32'hffe0);
    wr(TCNT0, 32'hffe0);
    for (int i = 0; i < 7; i++) begin
      wr(12'(12'h080 + 4 * CH[i]), CV[i]);
      wr(12'(12'h040 + 4 * CH[i]), CF[i]);
    end
    e0 = pm.edge_cnt;
    wr(TCTL0, 32'h8);
    repeat (66) @(posedge pclk);
    wr(TCTL0, 32'h0);
    cnt_chk(1, 2);
    cnt_chk(2, 4);
    cnt_chk(4, 1);
    cnt_chk(5, 4);
    cnt_chk(3, 0);
    cnt_chk(6, 0);
    check(32'(pin_oe_n & 16'h007e), 32'h48);
    apb(1'b0, ISTAT, 32'h0);
    check(rd, 32'h1207e);
    apb(1'b0, TCNT0, 32'h0);
    // 69 ticks from 0xffe0 with a 32-tick period end at 0xffe5
    check(rd, 32'hffe5);
    wr(ISTAT, 32'hffffffff);
    $display("test compare done");
    // Capture with the timers stopped, so the latched value is exact
    wr(TCNT0, 32'h1234);
    wr(TCNT1, 32'h0abc);
    wr(IMASK, 32'h0);
    wr(12'h040, 32'h41);
    wr(12'h064, 32'hc9);
    wr(12'h05c, 32'h81);
    pm.drive(0, 1'b1);
    pm.drive(9, 1'b1);
    pm.drive(7, 1'b1);
    repeat (8) @(posedge pclk);
    rchk(12'h080, 32'h1234);
    rchk(12'h0a4, 32'h0abc);
    rchk(ISTAT, 32'h201);
    rchk(PINST, 32'h02910010);
    check(32'(irq), 32'h0);
    wr(IMASK, 32'h1);
    wait_irq(1'b1);
    wr(ISTAT, 32'h1);
    wait_irq(1'b0);
    pm.drive(7, 1'b0);
    pm.drive(9, 1'b0);
    repeat (8) @(posedge pclk);
    rchk(ISTAT, 32'h280);
    $display("test capture done");
    wr(TCNT1, 32'h0);
    wr(TCTL1, 32'hd);
    repeat (3) begin
      @(posedge pclk);
      nb_ovf <= 1;
      @(posedge pclk);
      nb_ovf <= 0;
    end
    rchk(TCNT1, 32'h3);
    wr(TCTL1, 32'he);
    repeat (2) begin
      ext_count[1] <= 1;
      repeat (4) @(posedge pclk);
      ext_count[1] <= 0;
      repeat (4) @(posedge pclk);
    end
    rchk(TCNT1, 32'h5);
    // Divide by 8 and staggered both give one tick per 8 cycles
    for (int k = 0; k < 2; k++) begin
      wr(TCTL1, 32'h0);
      wr(TCNT1, 32'h0);
      wr(GCTL, 32'(k));
      wr(TCTL1, k ? 32'h8 : 32'hb);
      repeat (80) @(posedge pclk);
      wr(TCTL1, 32'h0);
      apb(1'b0, TCNT1, 32'h0);
      check(32'(rd >= 32'd9 && rd <= 32'd12), 32'h1);
    end
    $display("test clocks done");
    test_done();
  end
  initial begin
    repeat (100000) @(posedge pclk);
    err_count++;
    test_done();
  end
endmodule
